// ===== hdl/tmr_pkg.sv
/*
  Constants, register map and types of the input-driven 16-bit timer.
  Assumes a 32-bit APB master and one timer input pin from outside the clock domain.
*/
// Behaviour
// [RULE_01] Mode field: 100 ext trigger, 010 event count, 101 window, 110 pulse width.
// [RULE_02] Ext trigger: counting on source clock starts at selected edge; 0 rising, 1 falling.
// [RULE_03] Ext trigger: match with A interrupts, clears counter, keeps counting.
// [RULE_04] Retrigger-stop at 1: opposite edge stops and clears; next trigger restarts.
// [RULE_05] Retrigger-stop at 0: all pin edges ignored while counting to match.
// [RULE_06] Clearing run bit stops the counter and clears it in every mode.
// [RULE_07] While running, mode register and overflow enable writes are ignored.
// [RULE_08] Event mode: count each selected edge; match with A interrupts and clears.
// [RULE_09] Event source holds each level two cycles at least, rate below half clock.
// [RULE_10] Window mode: select 0 counts while input high, 1 while low.
// [RULE_11] Window mode: count ticks only at chosen level; match interrupts and clears.
// [RULE_12] Pulse width mode: edge select 0 starts on rising, 1 on falling.
// [RULE_13] Capture mode bit 0 gives double-edge capture, 1 single-edge capture.
// [RULE_14] Starting pulse width mode clears capture registers A and B.
// [RULE_15] Start edge interrupts and starts count; opposite edge captures B, flag, interrupt.
// [RULE_16] Double-edge: keep counting; next start edge captures A, flags, clears counter.
// [RULE_17] Single-edge: opposite edge stops and clears; next start edge interrupts, resumes.
// [RULE_18] Overflow while capturing sets flag; interrupt only if overflow enable set.
// [RULE_19] Reading the status register clears both capture flags and overflow flag.
// [RULE_20] Software reads captured values before the next trigger edge.
// [RULE_21] Opposite edge seen first after start: no capture, no interrupt.
// [RULE_22] Low byte write goes to holding buffer; high byte write commits 16 bits. Code ignores high byte writes in pulse width mode.
// [RULE_23] Auto capture: reading B low samples live counter and loads high byte.
// [RULE_24] Input pin synchronised before edge detection; one action per edge.
package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int PRE_W = 10;

  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DRA_L = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DRA_H = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_DRB_L = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DRB_H = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CNT = 8'h1C;

  localparam logic [2:0] MODE_EXT = 3'h4;
  localparam logic [2:0] MODE_EVT = 3'h2;
  localparam logic [2:0] MODE_WIN = 3'h5;
  localparam logic [2:0] MODE_PWM = 3'h6;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_OVFIE = 1;
  localparam int CTRL_ACAP = 2;
  localparam int STAT_CPA = 0;
  localparam int STAT_CPB = 1;
  localparam int STAT_OVF = 2;

  // Source clock dividers 1024, 64, 4 and 2 as all-ones masks
  localparam logic [PRE_W-1:0] DIV_MASK_0 = 10'h3FF;
  localparam logic [PRE_W-1:0] DIV_MASK_1 = 10'h03F;
  localparam logic [PRE_W-1:0] DIV_MASK_2 = 10'h003;
  localparam logic [PRE_W-1:0] DIV_MASK_3 = 10'h001;

  localparam logic [CNT_W-1:0] DR_RESET = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  typedef struct packed {
    logic cap_single;
    logic retrig_stop;
    logic edge_sel;
    logic [1:0] clk_sel;
    logic [2:0] op_mode;
  } mode_cfg_t;

  localparam mode_cfg_t MODE_RESET = 8'h00;

  typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_AFTER} phase_t;
endpackage : tmr_pkg

// ===== hdl/input_timer.sv
/*
  Input-driven 16-bit timer: external trigger, event count, window and pulse width
  modes, with an APB register slave. Assumes TIN_I is asynchronous to CLK_I.
*/
`timescale 1ns/1ps
module input_timer (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [tmr_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [tmr_pkg::DATA_W-1:0] PWDATA_I,
  output logic PREADY_O,
  output logic [tmr_pkg::DATA_W-1:0] PRDATA_O,
  output logic PSLVERR_O,
  input wire logic TIN_I,
  output logic TIRQ_O
);
  import tmr_pkg::*;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  function automatic logic [PRE_W-1:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0: div_mask = DIV_MASK_0;
      2'h1: div_mask = DIV_MASK_1;
      2'h2: div_mask = DIV_MASK_2;
      default: div_mask = DIV_MASK_3;
    endcase
  endfunction : div_mask

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    hit = (a == o);
  endfunction : hit

  mode_cfg_t cfg_q;
  logic run_q;
  logic ovf_ie_q;
  logic acap_q;
  logic [7:0] hold_q;
  logic [7:0] acap_hi_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cap_b_q;
  logic [2:0] flags_q;
  logic irq_q;
  phase_t st_q;
  logic [PRE_W-1:0] pre_q;
  logic tin_s1_q;
  logic tin_s2_q;
  logic tin_prev_q;
  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rdata;
  logic mapped;

  logic setup;
  logic wr_done;
  logic rd_done;
  logic run_start;
  logic rise;
  logic fall;
  logic trig;
  logic opp;
  logic win_level;
  logic tick;
  logic match;
  logic pwm;

  assign setup = PSEL_I & PENABLE_I & ~pready_q;
  assign wr_done = PSEL_I & PENABLE_I & pready_q & PWRITE_I;
  assign rd_done = PSEL_I & PENABLE_I & pready_q & ~PWRITE_I;
  assign run_start = wr_done & hit(PADDR_I, OFF_CTRL) & PWDATA_I[CTRL_RUN] & ~run_q;
  assign pwm = (cfg_q.op_mode == MODE_PWM);

  // Pin synchroniser and edge detect
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tin_s1_q <= 1'b0;
      tin_s2_q <= 1'b0;
      tin_prev_q <= 1'b0;
    end else begin
      tin_s1_q <= TIN_I; // [RULE_24]
      tin_s2_q <= tin_s1_q;
      tin_prev_q <= tin_s2_q;
    end
  end

  assign rise = tin_s2_q & ~tin_prev_q; // [RULE_24]
  assign fall = ~tin_s2_q & tin_prev_q;
  assign trig = cfg_q.edge_sel ? fall : rise; // [RULE_02] [RULE_12]
  assign opp = cfg_q.edge_sel ? rise : fall;
  assign win_level = tin_s2_q ^ cfg_q.edge_sel; // [RULE_10]

  // Source clock prescaler
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign tick = ((pre_q & div_mask(cfg_q.clk_sel)) == div_mask(cfg_q.clk_sel));
  assign match = (cnt_q == cmp_a_q);

  // Configuration and control registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_q <= MODE_RESET;
      run_q <= 1'b0;
      ovf_ie_q <= 1'b0;
      acap_q <= 1'b0;
      hold_q <= 8'h00;
    end else if (wr_done) begin
      if (hit(PADDR_I, OFF_MODE) && !run_q) begin
        cfg_q <= PWDATA_I[7:0]; // [RULE_07]
      end
      if (hit(PADDR_I, OFF_CTRL)) begin
        run_q <= PWDATA_I[CTRL_RUN];
        acap_q <= PWDATA_I[CTRL_ACAP];
        if (!run_q) begin
          ovf_ie_q <= PWDATA_I[CTRL_OVFIE]; // [RULE_07]
        end
      end
      if (hit(PADDR_I, OFF_DRA_L) || hit(PADDR_I, OFF_DRB_L)) begin
        hold_q <= PWDATA_I[7:0]; // [RULE_22]
      end
    end
  end

  // Counter, capture registers, flags and interrupt
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cnt_q <= CNT_ZERO;
      cmp_a_q <= DR_RESET;
      cap_b_q <= DR_RESET;
      flags_q <= 3'h0;
      irq_q <= 1'b0;
      st_q <= ST_WAIT;
    end else begin
      irq_q <= 1'b0;
      // Only bits actually returned are cleared, so a later set is kept
      if (rd_done && hit(PADDR_I, OFF_STAT)) begin
        flags_q <= flags_q & ~prdata_q[2:0]; // [RULE_19]
      end
      if (wr_done && hit(PADDR_I, OFF_DRA_H) && !pwm) begin
        cmp_a_q <= {PWDATA_I[7:0], hold_q}; // [RULE_22]
      end
      if (wr_done && hit(PADDR_I, OFF_DRB_H) && !pwm) begin
        cap_b_q <= {PWDATA_I[7:0], hold_q}; // [RULE_22]
      end
      if (!run_q) begin
        cnt_q <= CNT_ZERO; // [RULE_06]
        st_q <= ST_WAIT;
        if (run_start && pwm) begin
          cmp_a_q <= CNT_ZERO; // [RULE_14]
          cap_b_q <= CNT_ZERO;
        end
      end else begin
        case (cfg_q.op_mode) // [RULE_01]
          MODE_EXT: begin
            case (st_q)
              ST_WAIT: begin
                if (trig) begin
                  st_q <= ST_COUNT; // [RULE_02]
                end
              end
              default: begin
                if (cfg_q.retrig_stop && opp) begin
                  cnt_q <= CNT_ZERO; // [RULE_04]
                  st_q <= ST_WAIT;
                end else if (tick) begin
                  // Pin edges do not reach here without retrigger-stop
                  if (match) begin // [RULE_05]
                    cnt_q <= CNT_ZERO; // [RULE_03]
                    irq_q <= 1'b1;
                  end else begin
                    cnt_q <= cnt_q + 1'b1;
                  end
                end
              end
            endcase
          end
          MODE_EVT: begin
            if (trig) begin // [RULE_09]
              if (match) begin
                cnt_q <= CNT_ZERO; // [RULE_08]
                irq_q <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          MODE_WIN: begin
            if (tick && win_level) begin
              if (match) begin
                cnt_q <= CNT_ZERO; // [RULE_11]
                irq_q <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          MODE_PWM: begin
            case (st_q)
              ST_WAIT: begin
                // Opposite edge here is ignored entirely
                if (trig) begin // [RULE_21]
                  irq_q <= 1'b1; // [RULE_15] [RULE_17]
                  cnt_q <= CNT_ZERO;
                  st_q <= ST_COUNT;
                end
              end
              ST_COUNT: begin
                if (opp) begin
                  cap_b_q <= cnt_q; // [RULE_15]
                  flags_q[STAT_CPB] <= 1'b1;
                  irq_q <= 1'b1;
                  if (cfg_q.cap_single) begin // [RULE_13]
                    cnt_q <= CNT_ZERO; // [RULE_17]
                    st_q <= ST_WAIT;
                  end else begin
                    st_q <= ST_AFTER; // [RULE_16]
                  end
                end else if (tick) begin
                  cnt_q <= cnt_q + 1'b1;
                  if (cnt_q == CNT_MAX) begin
                    flags_q[STAT_OVF] <= 1'b1; // [RULE_18]
                    irq_q <= ovf_ie_q;
                  end
                end
              end
              default: begin
                if (trig) begin
                  cmp_a_q <= cnt_q; // [RULE_16]
                  flags_q[STAT_CPA] <= 1'b1;
                  irq_q <= 1'b1;
                  cnt_q <= CNT_ZERO;
                  st_q <= ST_COUNT;
                end else if (tick) begin
                  cnt_q <= cnt_q + 1'b1;
                  if (cnt_q == CNT_MAX) begin
                    flags_q[STAT_OVF] <= 1'b1; // [RULE_18]
                    irq_q <= ovf_ie_q;
                  end
                end
              end
            endcase
          end
          default: begin
            cnt_q <= CNT_ZERO;
          end
        endcase
      end
    end
  end

  // Auto capture high byte latched by the low byte read
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      acap_hi_q <= 8'h00;
    end else if (rd_done && acap_q && hit(PADDR_I, OFF_DRB_L)) begin
      acap_hi_q <= run_q ? cnt_q[15:8] : 8'h00; // [RULE_23]
    end
  end

  // Read mux
  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    case (PADDR_I)
      OFF_MODE: rdata[7:0] = cfg_q;
      OFF_CTRL: rdata[2:0] = {acap_q, ovf_ie_q, run_q};
      OFF_DRA_L: rdata[7:0] = cmp_a_q[7:0];
      OFF_DRA_H: rdata[7:0] = cmp_a_q[15:8];
      OFF_DRB_L: begin
        if (acap_q) begin
          rdata[7:0] = run_q ? cnt_q[7:0] : 8'h00; // [RULE_23]
        end else begin
          rdata[7:0] = cap_b_q[7:0];
        end
      end
      OFF_DRB_H: rdata[7:0] = acap_q ? acap_hi_q : cap_b_q[15:8];
      OFF_STAT: rdata[2:0] = flags_q;
      OFF_CNT: rdata[CNT_W-1:0] = cnt_q;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= ~mapped;
        prdata_q <= PWRITE_I ? '0 : rdata;
      end
    end
  end

  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;
  assign TIRQ_O = irq_q;

  sequence s_pwm_opp;
    run_q && pwm && st_q == ST_COUNT && opp;
  endsequence

  // Status read in a cycle that cannot set any flag again
  sequence s_stat_read;
    rd_done && hit(PADDR_I, OFF_STAT) && !opp && !trig && !(tick && cnt_q == CNT_MAX);
  endsequence

  // Rule checks, sampled on CLK_I

  a_run_clear_cnt: assert property ($fell(run_q) |=> cnt_q == CNT_ZERO) // [RULE_06]
    else $error("counter not cleared after stop");
  a_cfg_locked: assert property ($past(run_q) |-> $stable(cfg_q) && $stable(ovf_ie_q)) // [RULE_07]
    else $error("mode changed while running");
  a_evt_match: assert property (run_q && cfg_q.op_mode == MODE_EVT && trig && match // [RULE_08]
    |=> cnt_q == CNT_ZERO && irq_q)
    else $error("event match did not clear");
  a_ext_wait: assert property (run_q && cfg_q.op_mode == MODE_EXT && st_q == ST_WAIT // [RULE_02]
    |=> cnt_q == CNT_ZERO)
    else $error("ext timer counted before trigger");
  a_retrig_stop: assert property (run_q && cfg_q.op_mode == MODE_EXT && st_q == ST_COUNT // [RULE_04]
    && cfg_q.retrig_stop && opp |=> st_q == ST_WAIT && cnt_q == CNT_ZERO)
    else $error("retrigger stop failed");
  a_pwm_capb: assert property (s_pwm_opp |=> cap_b_q == $past(cnt_q) // [RULE_15]
    && flags_q[STAT_CPB] && irq_q)
    else $error("capture B failed");
  a_pwm_capa: assert property (run_q && pwm && st_q == ST_AFTER && trig // [RULE_16]
    |=> cmp_a_q == $past(cnt_q) && flags_q[STAT_CPA] && cnt_q == CNT_ZERO)
    else $error("capture A failed");
  a_first_opp: assert property (run_q && pwm && st_q == ST_WAIT && opp // [RULE_21]
    |=> !irq_q && st_q == ST_WAIT)
    else $error("capture on first opposite edge");
  a_ovf_flag: assert property (run_q && pwm && st_q != ST_WAIT && !opp && !trig // [RULE_18]
    && tick && cnt_q == CNT_MAX |=> flags_q[STAT_OVF] && irq_q == ovf_ie_q)
    else $error("overflow flag wrong");
  a_win_gate: assert property (run_q && cfg_q.op_mode == MODE_WIN && !win_level // [RULE_11]
    |=> $stable(cnt_q))
    else $error("window counted outside level");
  a_pwm_init: assert property (run_start && pwm |=> cmp_a_q == CNT_ZERO // [RULE_14]
    && cap_b_q == CNT_ZERO)
    else $error("capture registers not initialised");
  a_stat_clear: assert property (s_stat_read // [RULE_19]
    |=> (flags_q & $past(prdata_q[2:0])) == 3'h0)
    else $error("status read did not clear");
  a_edge_once: assert property (run_q && cfg_q.op_mode == MODE_EVT && !trig // [RULE_24]
    |=> $stable(cnt_q))
    else $error("counter moved without an edge");
  a_evt_step: assert property (run_q && cfg_q.op_mode == MODE_EVT // [RULE_08]
    && trig && !match |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("event edge not counted once");
  a_win_step: assert property (run_q && cfg_q.op_mode == MODE_WIN // [RULE_11]
    && win_level && tick && !match |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("window tick not counted");
  a_ext_match: assert property (run_q && cfg_q.op_mode == MODE_EXT // [RULE_03]
    && st_q == ST_COUNT && !(cfg_q.retrig_stop && opp) && tick && match
    |=> cnt_q == CNT_ZERO && irq_q)
    else $error("trigger timer match did not clear");
  a_single_stop: assert property (run_q && pwm && st_q == ST_COUNT && opp // [RULE_17]
    && cfg_q.cap_single |=> cnt_q == CNT_ZERO && st_q == ST_WAIT)
    else $error("single capture did not stop");
endmodule : input_timer

// ===== verification/pulse_source.sv
/*
  Far-side model: a digital pulse or event source on the timer input pin.
  Assumes the caller enters its task just after a rising edge of CLK_I.
*/
`timescale 1ns/1ps
module pulse_source (
  input wire logic CLK_I,
  output logic TIN_O
);
  initial TIN_O = 1'b0;

  // Sets a level and holds it, never shorter than two clocks
  task automatic drive(input logic lvl, input int hold);
    int n;
    n = (hold < 2) ? 2 : hold;
    TIN_O <= lvl;
    repeat (n) @(posedge CLK_I);
  endtask : drive
endmodule : pulse_source

// ===== verification/input_timer_bench.sv
/*
  Self-checking bench of the input-driven timer over APB, pin driven by pulse_source.
  Assumes the timer package and the timer module are compiled first.
*/
`timescale 1ns/1ps
module input_timer_bench;
  import tmr_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, tin, tirq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  int fails = 0;
  int checks = 0;
  int irqs = 0;
  int i0;
  int bv;

  input_timer dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PRDATA_O(prdata), .PSLVERR_O(pslverr), .TIN_I(tin), .TIRQ_O(tirq));
  pulse_source src (.CLK_I(clk), .TIN_O(tin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (tirq === 1'b1) irqs <= irqs + 1;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; returns with one idle edge passed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic seta(input logic [15:0] v);
    wr(OFF_DRA_L, {24'h000000, v[7:0]});
    wr(OFF_DRA_H, {24'h000000, v[15:8]});
  endtask : seta

  // Mode word with the fastest source clock
  function automatic logic [31:0] cfg(input logic cap1, input logic retr, input logic edg,
                                      input logic [2:0] md);
    return {24'h000000, cap1, retr, edg, 2'b11, md};
  endfunction : cfg

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(OFF_DRA_L, 32'h000000FF, "a_reset");
    rdchk(OFF_MODE, 32'h00000000, "mode_reset");
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    seta(16'h0003);
    wr(OFF_DRA_L, 32'h00000077);
    rdchk(OFF_DRA_L, 32'h00000003, "a_held");
    wr(OFF_DRA_H, 32'h00000000);
    rdchk(OFF_DRA_L, 32'h00000077, "a_commit");
    seta(16'h0003);
    $display("Test registers done");
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b0, MODE_EVT));
    wr(OFF_CTRL, 32'h00000001);
    i0 = irqs;
    repeat (4) begin
      src.drive(1'b1, 3);
      src.drive(1'b0, 3);
    end
    repeat (4) @(posedge clk);
    rdchk(OFF_CNT, 32'h00000000, "evt_wrap");
    chk("evt_irq", 32'(irqs - i0), 32'h1);
    src.drive(1'b1, 3);
    src.drive(1'b0, 3);
    src.drive(1'b1, 3);
    src.drive(1'b0, 6);
    rdchk(OFF_CNT, 32'h00000002, "evt_cnt");
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b0, MODE_WIN));
    rdchk(OFF_MODE, cfg(1'b0, 1'b0, 1'b0, MODE_EVT), "mode_lock");
    wr(OFF_CTRL, 32'h00000007);
    rdchk(OFF_CTRL, 32'h00000005, "ovfie_lock");
    rdchk(OFF_DRB_L, 32'h00000002, "acap_low");
    rdchk(OFF_DRB_H, 32'h00000000, "acap_high");
    wr(OFF_CTRL, 32'h00000000);
    rdchk(OFF_CNT, 32'h00000000, "stop_clear");
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b1, MODE_EVT));
    wr(OFF_CTRL, 32'h00000001);
    src.drive(1'b1, 4);
    rdchk(OFF_CNT, 32'h00000000, "rise_skip");
    src.drive(1'b0, 6);
    rdchk(OFF_CNT, 32'h00000001, "fall_cnt");
    $display("Test event done");
    wr(OFF_CTRL, 32'h00000000);
    seta(16'h00FF);
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b0, MODE_WIN));
    wr(OFF_CTRL, 32'h00000001);
    src.drive(1'b0, 30);
    rdchk(OFF_CNT, 32'h00000000, "win_idle");
    src.drive(1'b1, 40);
    src.drive(1'b0, 6);
    apb(1'b0, OFF_CNT, 32'h0);
    chk("win_cnt", 32'(rd >= 18 && rd <= 24), 32'h1);
    src.drive(1'b0, 20);
    rdchk(OFF_CNT, rd, "win_hold");
    wr(OFF_CTRL, 32'h00000000);
    src.drive(1'b1, 4);
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b1, MODE_WIN));
    wr(OFF_CTRL, 32'h00000001);
    src.drive(1'b1, 20);
    rdchk(OFF_CNT, 32'h00000000, "winlo_idle");
    src.drive(1'b0, 20);
    apb(1'b0, OFF_CNT, 32'h0);
    chk("winlo_cnt", 32'(rd >= 8 && rd <= 12), 32'h1);
    wr(OFF_CTRL, 32'h00000000);
    wr(OFF_MODE, cfg(1'b0, 1'b1, 1'b0, MODE_EXT));
    wr(OFF_CTRL, 32'h00000001);
    src.drive(1'b0, 20);
    rdchk(OFF_CNT, 32'h00000000, "ext_wait");
    src.drive(1'b1, 30);
    apb(1'b0, OFF_CNT, 32'h0);
    chk("ext_run", 32'(rd != 0), 32'h1);
    src.drive(1'b0, 6);
    rdchk(OFF_CNT, 32'h00000000, "ext_stop");
    wr(OFF_CTRL, 32'h00000000);
    seta(16'h0004);
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b0, MODE_EXT));
    wr(OFF_CTRL, 32'h00000001);
    i0 = irqs;
    src.drive(1'b1, 4);
    src.drive(1'b0, 40);
    chk("ext_irq", 32'(irqs - i0 >= 2), 32'h1);
    $display("Test trigger done");
    wr(OFF_CTRL, 32'h00000000);
    wr(OFF_MODE, cfg(1'b0, 1'b0, 1'b0, MODE_PWM));
    src.drive(1'b1, 6);
    wr(OFF_CTRL, 32'h00000001);
    rdchk(OFF_DRA_L, 32'h00000000, "pw_a_init");
    rdchk(OFF_DRB_H, 32'h00000000, "pw_b_init");
    i0 = irqs;
    src.drive(1'b0, 20);
    chk("pw_first", 32'(irqs - i0), 32'h0);
    rdchk(OFF_STAT, 32'h00000000, "pw_nostat");
    src.drive(1'b1, 20);
    chk("pw_start", 32'(irqs - i0), 32'h1);
    src.drive(1'b0, 8);
    rdchk(OFF_STAT, 32'h00000002, "pw_capb");
    rdchk(OFF_STAT, 32'h00000000, "pw_clr");
    apb(1'b0, OFF_DRB_L, 32'h0);
    bv = int'(rd);
    chk("pw_b", 32'(rd >= 9 && rd <= 11), 32'h1);
    src.drive(1'b0, 12);
    src.drive(1'b1, 8);
    rdchk(OFF_STAT, 32'h00000001, "pw_capa");
    apb(1'b0, OFF_DRA_L, 32'h0);
    chk("pw_a", 32'(int'(rd) > bv), 32'h1);
    wr(OFF_CTRL, 32'h00000000);
    wr(OFF_MODE, cfg(1'b1, 1'b0, 1'b0, MODE_PWM));
    wr(OFF_CTRL, 32'h00000001);
    src.drive(1'b0, 6);
    src.drive(1'b1, 20);
    src.drive(1'b0, 6);
    rdchk(OFF_CNT, 32'h00000000, "pw_single");
    rdchk(OFF_STAT, 32'h00000002, "pw_single_b");
    wr(OFF_CTRL, 32'h00000000);
    wr(OFF_MODE, cfg(1'b1, 1'b0, 1'b1, MODE_PWM));
    wr(OFF_CTRL, 32'h00000001);
    i0 = irqs;
    src.drive(1'b1, 6);
    chk("pw_fall_wait", 32'(irqs - i0), 32'h0);
    src.drive(1'b0, 6);
    chk("pw_fall_start", 32'(irqs - i0), 32'h1);
    $display("Test capture done");
    finish_test();
  end
endmodule : input_timer_bench
